/* File: verilog/sampler_run_control.sv */
// Sampler run control with alarms, an interlocked output held low and APB register access
`timescale 1ns/1ps
`default_nettype none
module sampler_run_control
	import sampler_pkg::*;
#(
	parameter int FAULT_COUNT = FAULT_CYCLES,
	parameter int FAULT_CNT_W = 30
) (
	// Clock, reset, enable
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic CLK_EN_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Sampler field contacts
	input wire logic SAMPLER_FAIL_IN_I,
	input wire logic RUNNING_FEEDBACK_I,
	input wire logic REMOTE_SELECTED_I,
	// Automatic request
	input wire logic AUTO_RUN_REQUEST_I,
	// Status outputs
	output logic SAMPLER_RUN_CMD_O,
	output logic MANUAL_MODE_FLAG_O,
	output logic FAIL_ALARM_O,
	output logic NO_FEEDBACK_ALARM_O,
	output logic INTERLOCKED_O,
	output logic IRQ_O
);
	// Bus state
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	// Control state
	logic manual_mode_flag_q, manual_mode_flag_d;
	logic demand_q, demand_d;
	logic run_q, run_d;
	logic fail_q, fail_d;
	logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
	logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
	// Decoded bus strobes and events
	logic wr_commit;
	logic select_auto_pulse, select_manual_pulse;
	logic operator_start_pulse, operator_stop_pulse;
	logic no_feedback_alarm;
	logic [IRQ_W-1:0] events;
	logic [31:0] status_word;

	// True for an offset this block answers to
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == CMD_OFS) || (a == STATUS_OFS) ||
			(a == IRQ_STAT_OFS) || (a == IRQ_MASK_OFS);
	endfunction

	// Write-one command pulses, low byte lane only
	assign wr_commit = PSEL_I && PENABLE_I && pready_q && PWRITE_I &&
		PSTRB_I[0];
	assign select_auto_pulse = wr_commit && (PADDR_I == CMD_OFS) &&
		PWDATA_I[CMD_AUTO_BIT]; // see (RL6)
	assign select_manual_pulse = wr_commit && (PADDR_I == CMD_OFS) &&
		PWDATA_I[CMD_MAN_BIT]; // see (RL6)
	assign operator_start_pulse = wr_commit && (PADDR_I == CMD_OFS) &&
		PWDATA_I[CMD_START_BIT]; // see (RL6)
	assign operator_stop_pulse = wr_commit && (PADDR_I == CMD_OFS) &&
		PWDATA_I[CMD_STOP_BIT]; // see (RL6)

	// Supervises feedback against the demand, not the gated output,
	// so the alarm holds while demand stays without feedback
	persist_timer #(
		.COUNT(FAULT_COUNT),
		.CNT_W(FAULT_CNT_W)
	) u_nofb (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RESETN_I),
		.ce_i(CLK_EN_I),
		.cond_i(REMOTE_SELECTED_I && demand_q && !RUNNING_FEEDBACK_I),
		.expired_o(no_feedback_alarm)
	); // see (RL4) (RL7)

	// Mode, demand, alarms and the gated run command
	always_comb begin
		manual_mode_flag_d = manual_mode_flag_q;
		if (select_manual_pulse) begin
			manual_mode_flag_d = 1'b1; // Manual wins a double select
		end else if (select_auto_pulse) begin
			manual_mode_flag_d = 1'b0;
		end
		demand_d = demand_q;
		if (manual_mode_flag_d != manual_mode_flag_q) begin
			demand_d = demand_q; // see (RL2)
		end else if (!manual_mode_flag_q) begin
			demand_d = AUTO_RUN_REQUEST_I; // see (RL1)
		end else if (operator_stop_pulse) begin
			demand_d = 1'b0; // see (RL8)
		end else if (operator_start_pulse) begin
			demand_d = 1'b1; // see (RL8)
		end
		fail_d = SAMPLER_FAIL_IN_I; // see (RL3)
		// Alarms override demand in both modes
		run_d = demand_d && !fail_d && !no_feedback_alarm; // see (RL5)
	end

	// Register only
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			manual_mode_flag_q <= 1'b0;
			demand_q <= 1'b0;
			run_q <= 1'b0;
			fail_q <= 1'b0;
		end else if (CLK_EN_I) begin
			manual_mode_flag_q <= manual_mode_flag_d;
			demand_q <= demand_d;
			run_q <= run_d;
			fail_q <= fail_d;
		end
	end

	// Event sources for the sticky status
	assign events[EV_FAIL_BIT] = fail_d && !fail_q;
	assign events[EV_NOFB_BIT] = no_feedback_alarm && !NO_FEEDBACK_ALARM_O;
	assign events[EV_START_BIT] = run_d && !run_q;
	assign events[EV_STOP_BIT] = !run_d && run_q;

	// Status word seen by software
	always_comb begin
		status_word = ZERO_WORD;
		status_word[ST_MAN_BIT] = manual_mode_flag_q;
		status_word[ST_RUN_BIT] = run_q;
		status_word[ST_FAIL_BIT] = fail_q;
		status_word[ST_NOFB_BIT] = no_feedback_alarm;
		status_word[ST_INTL_BIT] = 1'b0; // see (RL5)
		status_word[ST_DEMAND_BIT] = demand_q;
		status_word[ST_REM_BIT] = REMOTE_SELECTED_I;
		status_word[ST_FBK_BIT] = RUNNING_FEEDBACK_I;
		status_word[ST_FAILIN_BIT] = SAMPLER_FAIL_IN_I;
		status_word[ST_REQ_BIT] = AUTO_RUN_REQUEST_I;
		status_word[ST_PRIO_LSB +: 4] = ALARM_PRIORITY; // see (RL3) (RL4)
	end

	// One wait state: read data and error are captured on the same edge as pready
	always_comb begin
		pready_d = 1'b0;
		pslverr_d = pslverr_q;
		prdata_d = prdata_q;
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		if (PSEL_I && PENABLE_I && !pready_q) begin
			pready_d = 1'b1;
			pslverr_d = !mapped(PADDR_I);
			prdata_d = ZERO_WORD;
			if (!PWRITE_I) begin
				unique case (PADDR_I)
					STATUS_OFS: prdata_d = status_word;
					IRQ_STAT_OFS: prdata_d[IRQ_W-1:0] = irq_stat_q;
					IRQ_MASK_OFS: prdata_d[IRQ_W-1:0] = irq_mask_q;
					default: prdata_d = ZERO_WORD;
				endcase
			end
		end
		if (wr_commit && (PADDR_I == IRQ_MASK_OFS)) begin
			irq_mask_d = PWDATA_I[IRQ_W-1:0];
		end
		if (wr_commit && (PADDR_I == IRQ_STAT_OFS)) begin
			irq_stat_d = irq_stat_q & ~PWDATA_I[IRQ_W-1:0];
		end
		// Set wins over a same-cycle clear
		irq_stat_d = irq_stat_d | events;
	end

	// Register only
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= ZERO_WORD;
			irq_stat_q <= '0;
			irq_mask_q <= IRQ_MASK_RST;
		end else if (CLK_EN_I) begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
		end
	end

	// Outputs; alarm register for the no-feedback edge lives here
	logic nofb_q;
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			nofb_q <= 1'b0;
		end else if (CLK_EN_I) begin
			nofb_q <= no_feedback_alarm;
		end
	end

	assign NO_FEEDBACK_ALARM_O = nofb_q;
	assign SAMPLER_RUN_CMD_O = run_q;
	assign MANUAL_MODE_FLAG_O = manual_mode_flag_q;
	assign FAIL_ALARM_O = fail_q;
	assign INTERLOCKED_O = 1'b0; // Alarm stops never set interlocked
	assign IRQ_O = |(irq_stat_q & irq_mask_q);
	assign PREADY_O = pready_q;
	assign PSLVERR_O = pslverr_q && pready_q;
	assign PRDATA_O = prdata_q;
endmodule
`default_nettype wire

/* File: verilog/sampler_pkg.sv */
// Constants, register map and timing for the sampler run control block
// What this block does
// (RL1) Auto mode: run follows the auto request
// (RL2) Mode changeover leaves run command unchanged
// (RL3) Fail input raises self-clearing priority-2 alarm
// (RL4) Remote, running, no feedback 3 s: alarm
// (RL5) Either alarm forces run off, not interlocked
// (RL6) Operator start and stop are one-shot writes
// (RL7) Remote input high only under automation control
// (RL8) Manual mode: start latches run, stop clears
package sampler_pkg;
	// Register byte offsets
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
	// Command register bits, write one to act
	localparam int CMD_AUTO_BIT = 0;
	localparam int CMD_MAN_BIT = 1;
	localparam int CMD_START_BIT = 2;
	localparam int CMD_STOP_BIT = 3;
	// Status register bits
	localparam int ST_MAN_BIT = 0;
	localparam int ST_RUN_BIT = 1;
	localparam int ST_FAIL_BIT = 2;
	localparam int ST_NOFB_BIT = 3;
	localparam int ST_INTL_BIT = 4;
	localparam int ST_DEMAND_BIT = 5;
	localparam int ST_REM_BIT = 6;
	localparam int ST_FBK_BIT = 7;
	localparam int ST_FAILIN_BIT = 8;
	localparam int ST_REQ_BIT = 9;
	localparam int ST_PRIO_LSB = 12;
	localparam logic [3:0] ALARM_PRIORITY = 4'h2;
	// Interrupt event bits
	localparam int IRQ_W = 4;
	localparam int EV_FAIL_BIT = 0;
	localparam int EV_NOFB_BIT = 1;
	localparam int EV_START_BIT = 2;
	localparam int EV_STOP_BIT = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
	// Feedback supervision time
	localparam int FAULT_DELAY_S = 3;
	localparam int CLK_HZ = 200_000_000;
	localparam int FAULT_CYCLES = FAULT_DELAY_S * CLK_HZ;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

/* File: verilog/persist_timer.sv */
// Persistence timer: flags a condition held continuously for a set count
`timescale 1ns/1ps
`default_nettype none
module persist_timer #(
	parameter int COUNT = 600_000_000,
	parameter int CNT_W = 30
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Condition and result
	input wire logic cond_i,
	output logic expired_o
);
	localparam logic [CNT_W-1:0] LIMIT = CNT_W'(COUNT - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic exp_q, exp_d;

	// Refuse counts the counter cannot reach
	if (COUNT < 1 || COUNT > (2 ** CNT_W)) begin : g_bad
		$error("persist_timer: COUNT out of range for CNT_W");
	end

	// Count while the condition holds, restart when it drops
	always_comb begin
		cnt_d = cnt_q;
		exp_d = exp_q;
		if (!cond_i) begin
			cnt_d = CNT_ZERO;
			exp_d = 1'b0;
		end else if (cnt_q == LIMIT) begin
			exp_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	// Register only
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_q <= CNT_ZERO;
			exp_q <= 1'b0;
		end else if (ce_i) begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign expired_o = exp_q;
endmodule
`default_nettype wire

/* File: testbench/sampler_run_control_properties.sv */
// Port-level assertions for the sampler run control block
`timescale 1ns/1ps
`default_nettype none
module sampler_run_control_properties #(
	parameter int FAULT_COUNT = 20
) (
	// Clock, reset, enable
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic CLK_EN_I,
	// Field contacts and request
	input wire logic SAMPLER_FAIL_IN_I,
	input wire logic RUNNING_FEEDBACK_I,
	input wire logic REMOTE_SELECTED_I,
	input wire logic AUTO_RUN_REQUEST_I,
	// Outputs under watch
	input wire logic SAMPLER_RUN_CMD_O,
	input wire logic MANUAL_MODE_FLAG_O,
	input wire logic FAIL_ALARM_O,
	input wire logic NO_FEEDBACK_ALARM_O,
	input wire logic INTERLOCKED_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	int stuck_d, stuck_q;
	// Demand is hidden here, so this count can only run ahead
	always_comb stuck_d = !CLK_EN_I ? stuck_q :
		(REMOTE_SELECTED_I && !RUNNING_FEEDBACK_I) ? stuck_q + 1 : 0;
	always_ff @(posedge CORE_CLK_I) stuck_q <= RESETN_I ? stuck_d : 0;
	a_fail_alarm_tracks: assert property (
		CLK_EN_I |=> FAIL_ALARM_O == $past(SAMPLER_FAIL_IN_I))
		else $error("fail alarm lags wrongly");
	a_fail_stops_run: assert property (
		FAIL_ALARM_O |-> !SAMPLER_RUN_CMD_O)
		else $error("run on in fail alarm");
	a_nofb_stops_run: assert property (
		NO_FEEDBACK_ALARM_O |-> !SAMPLER_RUN_CMD_O)
		else $error("run on in run fault alarm");
	a_never_interlocked: assert property (
		!INTERLOCKED_O)
		else $error("interlocked set");
	a_auto_drops_run: assert property (
		CLK_EN_I && !MANUAL_MODE_FLAG_O && !AUTO_RUN_REQUEST_I
		|=> !SAMPLER_RUN_CMD_O || MANUAL_MODE_FLAG_O)
		else $error("auto run without request");
	a_mode_change_bumpless: assert property (
		$changed(MANUAL_MODE_FLAG_O) && !FAIL_ALARM_O && !$past(FAIL_ALARM_O)
		&& !NO_FEEDBACK_ALARM_O |-> $stable(SAMPLER_RUN_CMD_O))
		else $error("run stepped at mode change");
	a_nofb_not_early: assert property (
		$rose(NO_FEEDBACK_ALARM_O) |-> $past(stuck_q) >= FAULT_COUNT)
		else $error("run fault alarm too early");
	cover property ($rose(FAIL_ALARM_O));
	cover property ($rose(NO_FEEDBACK_ALARM_O));
	cover property ($changed(MANUAL_MODE_FLAG_O) && SAMPLER_RUN_CMD_O);
endmodule
`default_nettype wire

/* File: testbench/sampler_field_model.sv */
// Field side model: running feedback and remote contact
`timescale 1ns/1ps
`default_nettype none
module sampler_field_model (
	// Clock and command
	input wire logic clk_i,
	input wire logic run_cmd_i,
	// Bench controls
	input wire logic stall_i,
	input wire logic remote_i,
	// Contacts
	output logic running_feedback_o,
	output logic remote_selected_o
);
	logic [1:0] lag_q = 2'h0;
	// Feedback lags the command; a stalled machine never reports running
	always_ff @(posedge clk_i) lag_q <= {lag_q[0], run_cmd_i & ~stall_i};
	assign running_feedback_o = lag_q[1];
	// High only while automation holds control
	assign remote_selected_o = remote_i;
endmodule
`default_nettype wire

/* File: testbench/sampler_run_control_tb.sv */
// Self-checking bench for the sampler run control block
`timescale 1ns/1ps
`default_nettype none
module sampler_run_control_tb;
	import sampler_pkg::*;
	localparam int FC = 20;
	logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic fail_in = 1'b0, req = 1'b0, stall = 1'b0, remote = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] pstrb = 4'hF;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, r;
	logic pready, pslverr, run, man, fail_al, nofb, intl, irq, fbk, rsel, e;
	int miscompares = 0, checks_done = 0, cycles = 0;
	sampler_run_control #(.FAULT_COUNT(FC)) uut (.CORE_CLK_I(clk),
		.RESETN_I(resetn), .CLK_EN_I(clk_en), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PSTRB_I(pstrb),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.SAMPLER_FAIL_IN_I(fail_in), .RUNNING_FEEDBACK_I(fbk),
		.REMOTE_SELECTED_I(rsel), .AUTO_RUN_REQUEST_I(req),
		.SAMPLER_RUN_CMD_O(run), .MANUAL_MODE_FLAG_O(man),
		.FAIL_ALARM_O(fail_al), .NO_FEEDBACK_ALARM_O(nofb),
		.INTERLOCKED_O(intl), .IRQ_O(irq));
	sampler_field_model fm (.clk_i(clk), .run_cmd_i(run), .stall_i(stall),
		.remote_i(remote), .running_feedback_o(fbk), .remote_selected_o(rsel));
	// Clock and hang guard
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; idle edge after it so drives never collide
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		tick(1);
		pen <= 1'b1;
		do tick(1); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		tick(1);
	endtask
	task t_auto();
		remote <= 1'b1;
		req <= 1'b1;
		tick(4);
		chk(run, 1'b1);
		req <= 1'b0;
		tick(3);
		chk(run, 1'b0);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk(e, 1'b1);
		$display("t_auto done");
	endtask
	// Mode changes hold the run command; manual commands latch it
	task t_bump();
		req <= 1'b1;
		tick(3);
		apb(1'b1, CMD_OFS, 32'h0000_0002);
		chk(run, 1'b1);
		req <= 1'b0;
		tick(3);
		chk({man, run}, 2'h3);
		apb(1'b1, CMD_OFS, 32'h0000_0008);
		chk(run, 1'b0);
		apb(1'b1, CMD_OFS, 32'h0000_0004);
		chk(run, 1'b1);
		apb(1'b1, CMD_OFS, 32'h0000_0001);
		chk(run, 1'b1);
		tick(2);
		chk({man, run}, 2'h0);
		$display("t_bump done");
	endtask
	task t_fail();
		apb(1'b1, CMD_OFS, 32'h0000_0002);
		apb(1'b1, CMD_OFS, 32'h0000_0004);
		apb(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
		fail_in <= 1'b1;
		tick(3);
		chk({fail_al, run, intl, irq}, 4'h9);
		apb(1'b0, STATUS_OFS, 32'h0000_0000);
		chk(r[15:12], ALARM_PRIORITY);
		fail_in <= 1'b0;
		tick(3);
		apb(1'b1, IRQ_STAT_OFS, 32'h0000_0001);
		chk({fail_al, run, irq}, 3'h2);
		$display("t_fail done");
	endtask
	// Feedback withheld past the supervision time
	task t_nofb();
		int n;
		n = 0;
		stall <= 1'b1;
		tick(12);
		chk(nofb, 1'b0);
		while (nofb !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		chk({nofb, run, intl}, 3'h4);
		remote <= 1'b0;
		tick(4);
		chk(nofb, 1'b0);
		$display("t_nofb done");
	endtask
	// Enable low freezes alarms and run; a write without lane 0 is ignored
	task t_freeze();
		clk_en <= 1'b0;
		fail_in <= 1'b1;
		tick(3);
		chk({fail_al, run}, 2'h1);
		clk_en <= 1'b1;
		tick(2);
		chk({fail_al, run}, 2'h2);
		fail_in <= 1'b0;
		pstrb <= 4'hE;
		apb(1'b1, CMD_OFS, 32'h0000_0008);
		tick(1);
		chk(run, 1'b1);
		pstrb <= 4'hF;
		$display("t_freeze done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		tick(10);
		resetn <= 1'b1;
		tick(1);
		chk({run, man, fail_al, nofb, irq}, 5'h00);
		t_auto();
		t_bump();
		t_fail();
		t_nofb();
		t_freeze();
		summarize();
	end
endmodule
bind sampler_run_control sampler_run_control_properties #(
	.FAULT_COUNT(FAULT_COUNT)) props (.CORE_CLK_I, .RESETN_I, .CLK_EN_I,
	.SAMPLER_FAIL_IN_I, .RUNNING_FEEDBACK_I, .REMOTE_SELECTED_I,
	.AUTO_RUN_REQUEST_I, .SAMPLER_RUN_CMD_O, .MANUAL_MODE_FLAG_O,
	.FAIL_ALARM_O, .NO_FEEDBACK_ALARM_O, .INTERLOCKED_O);
`default_nettype wire
